// *** hdl/mmc_memmap.sv ***
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module mmc_memmap
  import mmc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic por_n_in,
  input wire logic stop_n_in,
  input wire logic mode_pin_zero_in,
  input wire logic mode_pin_one_in,
  input wire logic [MMC_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire mmc_prom_pins_t prom_pins_in,
  input wire logic [7:0] prom_data_in,
  output logic [7:0] prom_data_out,
  output logic prom_data_oe_out,
  output logic addr_data_port_ext_out,
  output logic [7:0] high_address_port_addr_out,
  output logic internal_ram_enable_out,
  output logic [2:0] prom_area_select_out,
  output logic prog_mode_out,
  output logic mode_illegal_out,
  output logic verify_mismatch_out
);

  function automatic logic [7:0] hi_mask(input logic [2:0] ext);
    case (ext)
      MMC_EXT_4K: hi_mask = MMC_HI_MASK_4K;
      MMC_EXT_16K: hi_mask = MMC_HI_MASK_16K;
      MMC_EXT_FULL: hi_mask = MMC_HI_MASK_FULL;
      default: hi_mask = MMC_HI_MASK_NONE;
    endcase
  endfunction

  function automatic logic ext_is_bus(input logic [2:0] ext);
    ext_is_bus = ext[2];
  endfunction

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic clear_map;
  assign clear_map = !rst_sync_reg || !stop_n_in;

  // memory map register
  mmc_map_t map_reg;
  mmc_map_t map_next;
  logic ram_en_reg;
  logic ram_en_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ext_bus_reg;
  logic ext_bus_next;
  logic [7:0] hi_addr_reg;
  logic [7:0] hi_addr_next;
  logic [7:0] status_byte;

  always_comb begin
    map_next = map_reg;
    ram_en_next = ram_en_reg;
    if (clear_map) begin
      map_next.external_extension_select = MMC_EXT_RESET;
      map_next.prom_area_select = MMC_AREA_RESET;
    end else if (reg_wr_in && reg_addr_in == MMC_REG_MAP_ADDR) begin
      map_next.external_extension_select = reg_wdata_in[MMC_EXT_LSB +: 3];
      map_next.prom_area_select = reg_wdata_in[MMC_AREA_LSB +: 3];
      ram_en_next = reg_wdata_in[MMC_RAM_BIT];
    end
    map_next.reserved = 1'b0;
    map_next.ram_enable_bit = ram_en_next;
    // bus mode drives the address/data port; port mode leaves direction to the port logic
    ext_bus_next = ext_is_bus(map_next.external_extension_select);
    // pins outside the mask remain general-purpose port pins
    hi_addr_next = hi_mask(map_next.external_extension_select);
  end

  assign status_byte = {5'h00, verify_mismatch_out, mode_illegal_out, prog_mode_out};

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        MMC_REG_MAP_ADDR: rdata_next = map_reg;
        MMC_REG_STATUS_ADDR: rdata_next = status_byte;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      map_reg.external_extension_select <= MMC_EXT_RESET;
      map_reg.prom_area_select <= MMC_AREA_RESET;
      map_reg.reserved <= 1'b0;
      map_reg.ram_enable_bit <= MMC_RAM_POR;
      ext_bus_reg <= 1'b0;
      hi_addr_reg <= MMC_HI_MASK_NONE;
      rdata_reg <= 8'h00;
    end else begin
      map_reg.external_extension_select <= map_next.external_extension_select;
      map_reg.prom_area_select <= map_next.prom_area_select;
      map_reg.reserved <= map_next.reserved;
      map_reg.ram_enable_bit <= map_next.ram_enable_bit;
      ext_bus_reg <= ext_bus_next;
      hi_addr_reg <= hi_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ram enable is not cleared by system reset, only by power-on or a map register write
  always_ff @(posedge clock_in or negedge por_n_in) begin
    if (!por_n_in) begin
      ram_en_reg <= MMC_RAM_POR;
    end else begin
      ram_en_reg <= ram_en_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign addr_data_port_ext_out = ext_bus_reg;
  assign high_address_port_addr_out = hi_addr_reg;
  assign internal_ram_enable_out = ram_en_reg;
  assign prom_area_select_out = map_reg.prom_area_select;

  // prom access logic runs while system reset is held, so it uses power-on reset only
  logic [7:0] prom_mem [0:MMC_PROM_WORDS-1];
  mmc_prom_pins_t pins_reg;
  logic [7:0] wdata_reg;
  mmc_prom_state_t state_reg;
  mmc_prom_state_t state_next;
  logic prog_reg;
  logic prog_next;
  logic illegal_reg;
  logic illegal_next;
  logic [7:0] last_data_reg;
  logic [7:0] last_data_next;
  logic mismatch_reg;
  logic mismatch_next;
  logic [7:0] dout_reg;
  logic [7:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic [7:0] cur_byte;

  initial begin
    for (int i = 0; i < MMC_PROM_WORDS; i++) begin
      prom_mem[i] = MMC_ERASED;
    end
  end

  assign cur_byte = prom_mem[pins_reg.prom_address];

  always_comb begin
    prog_next = !rstn_in && mode_pin_zero_in && !mode_pin_one_in;
    illegal_next = mode_pin_zero_in == mode_pin_one_in;
    state_next = PM_STANDBY;
    if (prog_reg) begin
      if (pins_reg.vpp_prog) begin
        // both enables low here is forbidden; held as inhibit
        case ({pins_reg.ce_n, pins_reg.oe_n})
          2'b01: state_next = PM_PROGRAM;
          2'b10: state_next = PM_VERIFY;
          default: state_next = PM_STANDBY;
        endcase
      end else begin
        case ({pins_reg.ce_n, pins_reg.oe_n})
          2'b00: state_next = PM_READ;
          2'b01: state_next = PM_OUTDIS;
          default: state_next = PM_STANDBY;
        endcase
      end
    end
    last_data_next = last_data_reg;
    mismatch_next = mismatch_reg;
    if (state_reg == PM_PROGRAM) begin
      last_data_next = wdata_reg;
    end
    if (state_reg == PM_VERIFY) begin
      mismatch_next = cur_byte != last_data_reg;
    end
    doe_next = state_next == PM_VERIFY || state_next == PM_READ;
    dout_next = doe_next ? cur_byte : 8'h00;
  end

  always_ff @(posedge clock_in or negedge por_n_in) begin
    if (!por_n_in) begin
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, vpp_prog: 1'b0, prom_address: '0};
      wdata_reg <= 8'h00;
      state_reg <= PM_STANDBY;
      prog_reg <= 1'b0;
      illegal_reg <= 1'b0;
      last_data_reg <= MMC_ERASED;
      mismatch_reg <= 1'b0;
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
    end else begin
      pins_reg <= prom_pins_in;
      wdata_reg <= prom_data_in;
      state_reg <= state_next;
      prog_reg <= prog_next;
      illegal_reg <= illegal_next;
      last_data_reg <= last_data_next;
      mismatch_reg <= mismatch_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  // writing can only clear bits, so nothing ever returns to erased
  // plain always: the erased fill above is a second writer of the array
  always @(posedge clock_in) begin
    if (state_reg == PM_PROGRAM) begin
      prom_mem[pins_reg.prom_address] <= cur_byte & wdata_reg;
    end
  end

  assign prom_data_out = dout_reg;
  assign prom_data_oe_out = doe_reg;
  assign prog_mode_out = prog_reg;
  assign mode_illegal_out = illegal_reg;
  assign verify_mismatch_out = mismatch_reg;

  sequence s_in_program;
    state_reg == PM_PROGRAM && $stable(pins_reg.prom_address);
  endsequence

  sequence s_verify_bad;
    state_reg == PM_VERIFY && cur_byte != last_data_reg;
  endsequence

  property p_prog_mode;
    @(posedge clock_in) disable iff (!por_n_in)
      (!rstn_in && mode_pin_zero_in && !mode_pin_one_in) |=> prog_mode_out;
  endproperty
  a_prog_mode: assert property (p_prog_mode) else $error("prom mode not entered");

  property p_ext_clear;
    @(posedge clock_in) disable iff (!rstn_in)
      !stop_n_in |=> map_reg.external_extension_select == MMC_EXT_RESET && !addr_data_port_ext_out;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("extension select not cleared");

  property p_area_clear;
    @(posedge clock_in) disable iff (!rstn_in)
      !stop_n_in |=> prom_area_select_out == MMC_AREA_RESET;
  endproperty
  a_area_clear: assert property (p_area_clear) else $error("prom area not reset");

  property p_ram_hold;
    @(posedge clock_in) disable iff (!por_n_in)
      !rst_sync_reg |=> $stable(internal_ram_enable_out);
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("ram enable changed in reset");

  property p_ram_write;
    @(posedge clock_in) disable iff (!rstn_in)
      (rst_sync_reg && stop_n_in && reg_wr_in && reg_addr_in == MMC_REG_MAP_ADDR)
        |=> internal_ram_enable_out == $past(reg_wdata_in[MMC_RAM_BIT]);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram enable write lost");

  property p_hi_port;
    @(posedge clock_in) disable iff (!rstn_in)
      map_reg.external_extension_select == MMC_EXT_PORT |-> high_address_port_addr_out == MMC_HI_MASK_NONE;
  endproperty
  a_hi_port: assert property (p_hi_port) else $error("port pins taken in port mode");

  property p_drive_out;
    @(posedge clock_in) disable iff (!por_n_in)
      (state_reg == PM_VERIFY || state_reg == PM_READ) |-> prom_data_oe_out;
  endproperty
  a_drive_out: assert property (p_drive_out) else $error("data lines not driven");

  property p_no_drive_prog;
    @(posedge clock_in) disable iff (!por_n_in)
      state_reg == PM_PROGRAM |-> !prom_data_oe_out ##1 !prom_data_oe_out || state_reg != PM_PROGRAM;
  endproperty
  a_no_drive_prog: assert property (p_no_drive_prog) else $error("driving during program");

  property p_otp;
    @(posedge clock_in) disable iff (!por_n_in)
      s_in_program ##1 $stable(pins_reg.prom_address) |-> (cur_byte & ~$past(cur_byte)) == 8'h00;
  endproperty
  a_otp: assert property (p_otp) else $error("erased bit restored");

  property p_mismatch;
    @(posedge clock_in) disable iff (!por_n_in)
      s_verify_bad |=> verify_mismatch_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

endmodule

// *** hdl/mmc_pkg.sv ***
package mmc_pkg;

  // register port
  localparam int MMC_ADDR_W = 8;
  localparam logic [7:0] MMC_REG_MAP_ADDR = 8'h00;
  localparam logic [7:0] MMC_REG_STATUS_ADDR = 8'h01;

  // memory_map_control field positions
  localparam int MMC_EXT_LSB = 0;
  localparam int MMC_RAM_BIT = 3;
  localparam int MMC_AREA_LSB = 5;

  // reset values
  localparam logic [2:0] MMC_EXT_RESET = 3'h0;
  localparam logic [2:0] MMC_AREA_RESET = 3'h0;
  localparam logic MMC_RAM_POR = 1'b0;

  // external_extension_select codes
  localparam logic [2:0] MMC_EXT_PORT = 3'h0;
  localparam logic [2:0] MMC_EXT_256B = 3'h4;
  localparam logic [2:0] MMC_EXT_4K = 3'h5;
  localparam logic [2:0] MMC_EXT_16K = 3'h6;
  localparam logic [2:0] MMC_EXT_FULL = 3'h7;

  // high_address_port pins used as address outputs per code
  localparam logic [7:0] MMC_HI_MASK_NONE = 8'h00;
  localparam logic [7:0] MMC_HI_MASK_4K = 8'h0f;
  localparam logic [7:0] MMC_HI_MASK_16K = 8'h3f;
  localparam logic [7:0] MMC_HI_MASK_FULL = 8'hff;

  // status register bit positions
  localparam int MMC_ST_PROG_BIT = 0;
  localparam int MMC_ST_ILLEGAL_BIT = 1;
  localparam int MMC_ST_MISMATCH_BIT = 2;

  // program store
  localparam int MMC_PROM_WORDS = 32768;
  localparam int MMC_PROM_AW = 15;
  localparam logic [7:0] MMC_ERASED = 8'hff;

  typedef struct packed {
    logic [2:0] prom_area_select;
    logic reserved;
    logic ram_enable_bit;
    logic [2:0] external_extension_select;
  } mmc_map_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic vpp_prog;
    logic [MMC_PROM_AW-1:0] prom_address;
  } mmc_prom_pins_t;

  typedef enum logic [2:0] {
    PM_STANDBY,
    PM_PROGRAM,
    PM_VERIFY,
    PM_READ,
    PM_OUTDIS
  } mmc_prom_state_t;

endpackage

// *** verif/mmc_prog_model.sv ***
`timescale 1ns/1ps
module mmc_prog_model
  import mmc_pkg::*;
#(
  // pulses scaled down to keep runs short; the store does not time them
  parameter int PULSE_CYC = 4
)(
  input wire logic clock_in,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  output mmc_prom_pins_t pins_out,
  output logic [7:0] wdata_out,
  output int attempts_out
);
  initial begin
    pins_out = '{ce_n: 1'b1, oe_n: 1'b1, vpp_prog: 1'b0, prom_address: '0};
    wdata_out = 8'h00;
    attempts_out = 0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic drive(input logic ce, input logic oe, input logic vpp);
    @(posedge clock_in);
    pins_out.ce_n <= ce;
    pins_out.oe_n <= oe;
    pins_out.vpp_prog <= vpp;
    // released data lines must not keep the old value
    wdata_out <= ~wdata_out;
    wait_cyc(4);
  endtask
  task automatic program_byte(input logic [14:0] a, input logic [7:0] d, output bit ok);
    logic [7:0] q;
    ok = 0;
    attempts_out = 0;
    @(posedge clock_in);
    pins_out <= '{ce_n: 1'b1, oe_n: 1'b1, vpp_prog: 1'b1, prom_address: a};
    wait_cyc(2);
    while (!ok && attempts_out < 25) begin
      attempts_out++;
      wdata_out <= d;
      wait_cyc(1);
      pins_out.ce_n <= 1'b0;
      wait_cyc(PULSE_CYC);
      pins_out.ce_n <= 1'b1;
      wait_cyc(1);
      pins_out.oe_n <= 1'b0;
      wdata_out <= ~d;
      wait_cyc(4);
      q = dev_data_in;
      ok = (q === d) && (dev_oe_in === 1'b1);
      pins_out.oe_n <= 1'b1;
      wait_cyc(1);
    end
    if (ok) begin
      wdata_out <= d;
      wait_cyc(1);
      pins_out.ce_n <= 1'b0;
      wait_cyc(3 * attempts_out * PULSE_CYC);
      pins_out.ce_n <= 1'b1;
      wait_cyc(2);
    end
  endtask
  task automatic read_byte(input logic [14:0] a, output logic [7:0] q);
    @(posedge clock_in);
    pins_out <= '{ce_n: 1'b0, oe_n: 1'b0, vpp_prog: 1'b0, prom_address: a};
    wdata_out <= ~wdata_out;
    wait_cyc(4);
    q = dev_data_in;
    pins_out.ce_n <= 1'b1;
    pins_out.oe_n <= 1'b1;
  endtask
endmodule

// *** verif/mmc_memmap_test.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module mmc_memmap_test;
  import mmc_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic por_n_in = 1'b0;
  logic stop_n_in = 1'b1;
  logic mode_pin_zero_in = 1'b0;
  logic mode_pin_one_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] rdata, pdata, hi_out, wdata, q, v, mon_exp;
  logic poe, ext_out, ram_out, prog_out, illegal_out, mism_out;
  logic [2:0] area_out;
  mmc_prom_pins_t pins;
  int attempts;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  logic rd_q1 = 1'b0;
  bit ok;
  logic [3:0] modes [5] = '{4'b0100, 4'b1000, 4'b1110, 4'b1011, 4'b0001};

  mmc_memmap uut (.clock_in(clock_in), .rstn_in(rstn_in), .por_n_in(por_n_in), .stop_n_in(stop_n_in),
    .mode_pin_zero_in(mode_pin_zero_in), .mode_pin_one_in(mode_pin_one_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
    .prom_pins_in(pins), .prom_data_in(wdata), .prom_data_out(pdata), .prom_data_oe_out(poe),
    .addr_data_port_ext_out(ext_out), .high_address_port_addr_out(hi_out), .internal_ram_enable_out(ram_out),
    .prom_area_select_out(area_out), .prog_mode_out(prog_out), .mode_illegal_out(illegal_out),
    .verify_mismatch_out(mism_out));
  mmc_prog_model #(.PULSE_CYC(4)) prog (.clock_in(clock_in), .dev_data_in(pdata), .dev_oe_in(poe),
    .pins_out(pins), .wdata_out(wdata), .attempts_out(attempts));

  always #50 clock_in = ~clock_in;

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_q1) begin
      mon_exp = exp_q.pop_front();
      `CHK(rdata, mon_exp)
    end
    rd_q1 <= reg_rd_in;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    @(negedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  function automatic logic [7:0] hmask(input logic [2:0] c);
    case (c)
      MMC_EXT_4K: return MMC_HI_MASK_4K;
      MMC_EXT_16K: return MMC_HI_MASK_16K;
      MMC_EXT_FULL: return MMC_HI_MASK_FULL;
      default: return MMC_HI_MASK_NONE;
    endcase
  endfunction

  initial begin
    void'($urandom(17));
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    por_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(MMC_REG_MAP_ADDR, 8'h00);
    rd(MMC_REG_STATUS_ADDR, 8'h00);
    wr(8'h5a, 8'hff);
    rd(8'h5a, 8'h00);
    rd(MMC_REG_MAP_ADDR, 8'h00);
    for (int c = 0; c < 8; c++) begin
      v = 8'($urandom());
      v[2:0] = 3'(c);
      wr(MMC_REG_MAP_ADDR, v);
      `CHK(ext_out, v[2])
      `CHK(hi_out, hmask(v[2:0]))
      `CHK(ram_out, v[3])
      `CHK(area_out, v[7:5])
      rd(MMC_REG_MAP_ADDR, v & 8'hef);
    end
    wr(MMC_REG_MAP_ADDR, 8'hbf);
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (3) @(negedge clock_in);
    `CHK(ext_out, 1'b0)
    `CHK(hi_out, 8'h00)
    `CHK(area_out, MMC_AREA_RESET)
    `CHK(ram_out, 1'b1)
    @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(MMC_REG_MAP_ADDR, 8'h08);
    // large extension with external ram: software drops the ram enable
    wr(MMC_REG_MAP_ADDR, 8'he7);
    @(posedge clock_in);
    stop_n_in <= 1'b0;
    wr(MMC_REG_MAP_ADDR, 8'h1d);
    `CHK(ext_out, 1'b0)
    `CHK(area_out, MMC_AREA_RESET)
    `CHK(ram_out, 1'b0)
    @(posedge clock_in);
    stop_n_in <= 1'b1;
    // reset stays low through every store access
    @(posedge clock_in);
    rstn_in <= 1'b0;
    mode_pin_zero_in <= 1'b1;
    mode_pin_one_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    `CHK(prog_out, 1'b1)
    `CHK(illegal_out, 1'b0)
    prog.read_byte(15'h1234, q);
    `CHK(q, MMC_ERASED)
    prog.program_byte(15'h0001, 8'hf0, ok);
    `CHK(ok, 1'b1)
    `CHK(mism_out, 1'b0)
    prog.program_byte(15'h0001, 8'h3c, ok);
    `CHK(ok, 1'b0)
    `CHK(attempts, 25)
    `CHK(mism_out, 1'b1)
    prog.read_byte(15'h0001, q);
    `CHK(q, 8'h30)
    v = 8'($urandom());
    prog.program_byte(15'h7fff, v, ok);
    `CHK(mism_out, 1'b0)
    prog.read_byte(15'h7fff, q);
    `CHK(q, v)
    for (int a = 2; a < 4; a++) begin
      prog.program_byte(15'(a), 8'(a * 8'h11), ok);
      `CHK(ok, 1'b1)
    end
    prog.read_byte(15'h0003, q);
    `CHK(q, 8'h33)
    prog.read_byte(15'h0000, q);
    `CHK(q, MMC_ERASED)
    for (int m = 0; m < 5; m++) begin
      prog.drive(modes[m][3], modes[m][2], modes[m][1]);
      `CHK(poe, modes[m][0])
    end
    prog.drive(1'b1, 1'b1, 1'b0);
    mode_pin_one_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK(illegal_out, 1'b1)
    `CHK(prog_out, 1'b0)
    mode_pin_zero_in <= 1'b0;
    mode_pin_one_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    `CHK(illegal_out, 1'b1)
    end_sim();
  end
endmodule
